// *** rtl/cid_decoder.sv ***
`timescale 1ns/1ps
`default_nettype none
module cid_decoder
   import cid_pkg::*;
(
   // clock and reset
   input  wire logic        CLK,
   input  wire logic        SRST,
   // opcode bytes from the prefetch queue
   input  wire cid_byte_s   OPC_IN,
   // operating mode, high in protected mode
   input  wire logic        MODE_PROT,
   // result to the execution sequencer
   output var  cid_result_s DEC_OUT
);

   // ---------------------------------------------------------------
   // byte sequencing
   // ---------------------------------------------------------------
   cid_state_e  st_q;
   cid_state_e  st_d;
   cid_result_s res_q;
   cid_result_s res_d;
   cid_instr_e  ins;
   cid_clk_t    cnt;
   logic        known;
   logic        need_modrm;
   logic        esc_hit;
   logic        emit;

   // the escape byte itself only arms the second-byte table
   assign esc_hit = OPC_IN.valid && (st_q == ST_IDLE) && (OPC_IN.data == OPC_ESCAPE);
   // a mod reg r/m byte is swallowed and never decoded as an opcode
   assign emit    = OPC_IN.valid && (st_q != ST_MODRM) && !esc_hit;

   cid_classify u_classify (
      .opc        (OPC_IN.data),
      .esc        (st_q == ST_ESC),
      .instr      (ins),
      .need_modrm (need_modrm)
   );

   cid_count_sel u_count (
      .instr  (ins),
      .prot   (MODE_PROT),
      .clocks (cnt),
      .known  (known)
   );

   always_comb begin
      st_d = st_q;
      if (OPC_IN.valid) begin
         case (st_q)
            ST_IDLE: begin
               if (esc_hit) begin
                  st_d = ST_ESC;
               end else if (need_modrm) begin
                  st_d = ST_MODRM;
               end else begin
                  st_d = ST_IDLE;
               end
            end
            ST_ESC:   st_d = need_modrm ? ST_MODRM : ST_IDLE;
            ST_MODRM: st_d = ST_IDLE;
            default:  st_d = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         st_q <= ST_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

   // ---------------------------------------------------------------
   // result register
   // ---------------------------------------------------------------
   // mode is taken in the cycle of the last opcode byte; a later
   // mode change does not rewrite a count already issued
   always_comb begin
      res_d            = '0;
      res_d.valid      = emit;
      res_d.known      = emit && known;
      res_d.escaped    = emit && (st_q == ST_ESC);
      res_d.modrm_next = emit && need_modrm;
      res_d.instr      = emit ? ins : INS_NONE;
      res_d.clocks     = emit ? cnt : CNT_NONE;
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         res_q <= '0;
      end else begin
         res_q <= res_d;
      end
   end

   assign DEC_OUT = res_q;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);

   sequence s_one(logic [7:0] b);
      (st_q == ST_IDLE) && OPC_IN.valid && (OPC_IN.data == b);
   endsequence

   sequence s_two(logic [7:0] b);
      (st_q == ST_ESC) && OPC_IN.valid && (OPC_IN.data == b);
   endsequence

   sequence s_count(cid_instr_e i, cid_clk_t r, cid_clk_t p);
      DEC_OUT.valid && DEC_OUT.known && (DEC_OUT.instr == i)
         && (DEC_OUT.clocks == ($past(MODE_PROT) ? p : r));
   endsequence

   AST_POP_FOURTH: assert property (
      s_two(OPC_POP_FOURTH_SEG)
         |=> s_count(INS_POP_FOURTH_SEG, CNT_POP_SEG_REAL, CNT_POP_SEG_PROT))
      else $error("pop into fourth segment has wrong count");

   AST_POP_FIFTH_PATH: assert property (
      s_one(OPC_ESCAPE) ##1 s_two(OPC_POP_FIFTH_SEG)
         |=> s_count(INS_POP_FIFTH_SEG, CNT_POP_SEG_REAL, CNT_POP_SEG_PROT))
      else $error("escaped pop into fifth segment has wrong count");

   AST_SWAP: assert property (
      (st_q == ST_IDLE) && OPC_IN.valid && (OPC_IN.data[7:3] == OPC_SWAP_ACC_HI)
         |=> s_count(INS_SWAP_OPERANDS, CNT_SWAP, CNT_SWAP))
      else $error("short swap has wrong count");

   AST_LOAD_EFF: assert property (
      s_one(OPC_LOAD_EFF_ADDR)
         |=> s_count(INS_LOAD_EFFECTIVE_ADDR, CNT_LOAD_EFF_ADDR, CNT_LOAD_EFF_ADDR)
             ##0 (st_q == ST_MODRM) && DEC_OUT.modrm_next)
      else $error("effective address load count or modrm skip wrong");

   AST_MODRM_SWALLOW: assert property (
      s_one(OPC_LOAD_EFF_ADDR) ##1 OPC_IN.valid |=> !DEC_OUT.valid ##0 (st_q == ST_IDLE))
      else $error("mod reg r/m byte was decoded as an opcode");

   AST_FAR_DATA: assert property (
      s_one(OPC_FAR_DATA_SEG)
         |=> s_count(INS_LOAD_FAR_PTR_DATA_SEG, CNT_FAR_REAL, CNT_FAR_DE_PROT))
      else $error("far load into data segment has wrong count");

   AST_FAR_EXTRA: assert property (
      s_one(OPC_FAR_EXTRA_SEG)
         |=> s_count(INS_LOAD_FAR_PTR_EXTRA_SEG, CNT_FAR_REAL, CNT_FAR_DE_PROT))
      else $error("far load into extra segment has wrong count");

   AST_FAR_FOURTH: assert property (
      s_two(OPC_FAR_FOURTH_SEG)
         |=> s_count(INS_LOAD_FAR_PTR_FOURTH_SEG, CNT_FAR_REAL, CNT_FAR_FOURTH_PROT))
      else $error("far load into fourth segment has wrong count");

   AST_FAR_FIFTH: assert property (
      s_two(OPC_FAR_FIFTH_SEG)
         |=> s_count(INS_LOAD_FAR_PTR_FIFTH_SEG, CNT_FAR_REAL, CNT_FAR_FOURTH_PROT))
      else $error("far load into fifth segment has wrong count");

   AST_FAR_STACK: assert property (
      s_two(OPC_FAR_STACK_SEG)
         |=> s_count(INS_LOAD_FAR_PTR_STACK_SEG, CNT_FAR_REAL, CNT_FAR_STACK_PROT)
             ##0 (st_q == ST_MODRM) && DEC_OUT.modrm_next)
      else $error("far load into stack segment has wrong count");

   AST_CLEAR_CARRY: assert property (
      s_one(OPC_CLEAR_CARRY)
         |=> s_count(INS_CLEAR_CARRY, CNT_CLEAR_CARRY, CNT_CLEAR_CARRY))
      else $error("clear carry has wrong count");

   AST_CLEAR_DIR: assert property (
      s_one(OPC_CLEAR_DIRECTION)
         |=> s_count(INS_CLEAR_DIRECTION, CNT_CLEAR_DIRECTION, CNT_CLEAR_DIRECTION))
      else $error("clear direction has wrong count");

   AST_CLEAR_IRQ: assert property (
      s_one(OPC_CLEAR_IRQ_EN)
         |=> s_count(INS_CLEAR_IRQ_ENABLE, CNT_CLEAR_IRQ_EN, CNT_CLEAR_IRQ_EN))
      else $error("clear interrupt enable has wrong count");

   AST_CLEAR_TASK: assert property (
      s_one(OPC_ESCAPE) ##1 s_two(OPC_CLEAR_TASK_SW)
         |=> s_count(INS_CLEAR_TASK_SWITCHED, CNT_CLEAR_TASK_SW, CNT_CLEAR_TASK_SW)
             ##0 DEC_OUT.escaped)
      else $error("clear task switched has wrong count");

   AST_TOGGLE_CARRY: assert property (
      s_one(OPC_TOGGLE_CARRY)
         |=> s_count(INS_TOGGLE_CARRY, CNT_TOGGLE_CARRY, CNT_TOGGLE_CARRY))
      else $error("toggle carry has wrong count");

   AST_FLAGS_TO_ACC: assert property (
      s_one(OPC_FLAGS_TO_ACC_HI)
         |=> s_count(INS_COPY_FLAGS_TO_ACC_HIGH, CNT_FLAGS_TO_ACC_HI, CNT_FLAGS_TO_ACC_HI))
      else $error("flags to accumulator high byte has wrong count");

   AST_ACC_TO_FLAGS: assert property (
      s_one(OPC_ACC_HI_TO_FLAGS)
         |=> s_count(INS_COPY_ACC_HIGH_TO_FLAGS, CNT_ACC_HI_TO_FLAGS, CNT_ACC_HI_TO_FLAGS))
      else $error("accumulator high byte to flags has wrong count");

   AST_MODE_FOLLOW: assert property (
      s_one(OPC_FAR_DATA_SEG) ##0 MODE_PROT
         |=> (DEC_OUT.clocks == CNT_FAR_DE_PROT) ##0 (DEC_OUT.instr == INS_LOAD_FAR_PTR_DATA_SEG))
      else $error("protected count not chosen in protected mode");

   AST_ESC_SILENT: assert property (
      s_one(OPC_ESCAPE) |=> !DEC_OUT.valid && (st_q == ST_ESC))
      else $error("escape byte produced a result");

   AST_NO_SPURIOUS: assert property (
      !$past(OPC_IN.valid) |-> !DEC_OUT.valid)
      else $error("result issued without an opcode byte");

   // prefix misuse, swallowed bytes, idle output and mode choice
   AST_RESET_CLEAR: assert property (disable iff (1'b0)
      SRST |=> (DEC_OUT == '0) && (st_q == ST_IDLE))
      else $error("reset left a result or state");

   AST_PLAIN_POP: assert property (
      s_one(OPC_POP_FIFTH_SEG)
         |=> DEC_OUT.valid && !DEC_OUT.known && !DEC_OUT.escaped)
      else $error("pop decoded without escape");

   AST_PLAIN_TASK: assert property (
      s_one(OPC_CLEAR_TASK_SW) |=> DEC_OUT.valid && !DEC_OUT.known)
      else $error("clear task switched decoded without escape");

   AST_ESC_SWAP: assert property (
      (st_q == ST_ESC) && OPC_IN.valid && (OPC_IN.data[7:3] == OPC_SWAP_ACC_HI)
         |=> DEC_OUT.valid && !DEC_OUT.known && DEC_OUT.escaped)
      else $error("escaped swap byte was recognised");

   AST_ESC_ONCE: assert property (
      (st_q == ST_ESC) && OPC_IN.valid |=> DEC_OUT.valid && DEC_OUT.escaped && (st_q != ST_ESC))
      else $error("escape not consumed by the next byte");

   AST_MODRM_ARMED: assert property (
      DEC_OUT.modrm_next |-> (st_q == ST_MODRM))
      else $error("mod reg r/m byte not awaited");

   AST_MODRM_FREE: assert property (
      (st_q == ST_MODRM) && OPC_IN.valid |=> !DEC_OUT.valid && (st_q == ST_IDLE))
      else $error("swallowed byte gave a result");

   AST_FAR_EXTRA_REAL: assert property (
      s_one(OPC_FAR_EXTRA_SEG) ##0 !MODE_PROT |=> (DEC_OUT.clocks == CNT_FAR_REAL))
      else $error("legacy count not chosen for far extra load");

   AST_FAR_FIFTH_PROT: assert property (
      s_two(OPC_FAR_FIFTH_SEG) ##0 MODE_PROT |=> (DEC_OUT.clocks == CNT_FAR_FOURTH_PROT))
      else $error("protected count not chosen for far fifth load");

   AST_POP_FIFTH_REAL: assert property (
      s_two(OPC_POP_FIFTH_SEG) ##0 !MODE_PROT |=> (DEC_OUT.clocks == CNT_POP_SEG_REAL))
      else $error("legacy count not chosen for pop");

   AST_POP_FOURTH_PROT: assert property (
      s_two(OPC_POP_FOURTH_SEG) ##0 MODE_PROT |=> (DEC_OUT.clocks == CNT_POP_SEG_PROT))
      else $error("protected count not chosen for pop");

   AST_FAR_STACK_REAL: assert property (
      s_two(OPC_FAR_STACK_SEG) ##0 !MODE_PROT |=> (DEC_OUT.clocks == CNT_FAR_REAL))
      else $error("legacy count not chosen for far stack load");

   AST_IDLE_ZERO: assert property (
      !DEC_OUT.valid |-> (DEC_OUT == '0))
      else $error("result fields set without valid");

   AST_KNOWN_COUNT: assert property (
      DEC_OUT.known |-> DEC_OUT.valid && (DEC_OUT.clocks != CNT_NONE) && (DEC_OUT.instr != INS_NONE))
      else $error("recognised opcode without a count");

   AST_UNKNOWN_ZERO: assert property (
      DEC_OUT.valid && !DEC_OUT.known
         |-> (DEC_OUT.clocks == CNT_NONE) && (DEC_OUT.instr == INS_NONE) && !DEC_OUT.modrm_next)
      else $error("unknown opcode carries a count");

   AST_SWAP_ALONE: assert property (
      (st_q == ST_IDLE) && OPC_IN.valid && (OPC_IN.data[7:3] == OPC_SWAP_ACC_HI)
         |=> !DEC_OUT.modrm_next && (st_q == ST_IDLE))
      else $error("short swap waited for a mod reg r/m byte");

   AST_MODE_LATE: assert property (
      s_one(OPC_FAR_DATA_SEG) ##0 !MODE_PROT ##1 MODE_PROT |-> (DEC_OUT.clocks == CNT_FAR_REAL))
      else $error("later mode change rewrote an issued count");

   AST_FAR_FOURTH_SKIP: assert property (
      s_one(OPC_ESCAPE) ##1 s_two(OPC_FAR_FOURTH_SEG) ##1 OPC_IN.valid
         |=> !DEC_OUT.valid && (st_q == ST_IDLE))
      else $error("byte after far fourth load was decoded");

endmodule // cid_decoder
`default_nettype wire

// *** rtl/cid_pkg.sv ***
// Summary of operation
// - escaped pop into fourth or fifth segment: 7 clocks legacy, 21 protected
// - short swap of register with accumulator, 10010 reg: 3 clocks always
// - effective-address load 10001101 plus mod reg r/m: 2 clocks always
// - far-pointer load into data segment: 7 clocks legacy, 22 protected
// - far-pointer load into extra segment, 11000100: 7 legacy, 22 protected
// - far-pointer load into fourth segment, escaped 10110100: 7 legacy, 25 protected
// - far-pointer load into fifth segment, escaped 10110101: 7 legacy, 25 protected
// - far-pointer load into stack segment, escaped 10110010: 7 legacy, 22 protected
// - clear carry, 11111000: 2 clocks in every mode
// - clear direction: 2 clocks in every mode
// - clear interrupt enable: 8 clocks in both modes
// - clear task switched, escape then 00000110: 6 clocks in all modes
// - toggle carry, 11110101: 2 clocks in all modes
// - copy flags to accumulator high byte, 10011111: 2 clocks always
// - copy accumulator high byte to flags, 10011110: 3 clocks always
package cid_pkg;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef logic [4:0] cid_clk_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_ESC   = 2'b01,
      ST_MODRM = 2'b10
   } cid_state_e;

   typedef enum logic [4:0] {
      INS_NONE                    = 5'h00,
      INS_POP_FOURTH_SEG          = 5'h01,
      INS_POP_FIFTH_SEG           = 5'h02,
      INS_SWAP_OPERANDS           = 5'h03,
      INS_LOAD_EFFECTIVE_ADDR     = 5'h04,
      INS_LOAD_FAR_PTR_DATA_SEG   = 5'h05,
      INS_LOAD_FAR_PTR_EXTRA_SEG  = 5'h06,
      INS_LOAD_FAR_PTR_FOURTH_SEG = 5'h07,
      INS_LOAD_FAR_PTR_FIFTH_SEG  = 5'h08,
      INS_LOAD_FAR_PTR_STACK_SEG  = 5'h09,
      INS_CLEAR_CARRY             = 5'h0A,
      INS_CLEAR_DIRECTION         = 5'h0B,
      INS_CLEAR_IRQ_ENABLE        = 5'h0C,
      INS_CLEAR_TASK_SWITCHED     = 5'h0D,
      INS_TOGGLE_CARRY            = 5'h0E,
      INS_COPY_FLAGS_TO_ACC_HIGH  = 5'h0F,
      INS_COPY_ACC_HIGH_TO_FLAGS  = 5'h10,
      INS_POP_FLAGS               = 5'h11,
      INS_PUSH_FLAGS              = 5'h12
   } cid_instr_e;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } cid_byte_s;

   typedef struct packed {
      logic       valid;
      logic       known;
      logic       escaped;
      logic       modrm_next;
      cid_instr_e instr;
      cid_clk_t   clocks;
   } cid_result_s;

   // ---------------------------------------------------------------
   // opcode bytes
   // ---------------------------------------------------------------
   localparam logic [7:0] OPC_ESCAPE          = 8'h0F;
   localparam logic [7:0] OPC_POP_FOURTH_SEG  = 8'hA1;
   localparam logic [7:0] OPC_POP_FIFTH_SEG   = 8'hA9;
   localparam logic [4:0] OPC_SWAP_ACC_HI     = 5'h12;
   localparam logic [7:0] OPC_LOAD_EFF_ADDR   = 8'h8D;
   localparam logic [7:0] OPC_FAR_DATA_SEG    = 8'hC5;
   localparam logic [7:0] OPC_FAR_EXTRA_SEG   = 8'hC4;
   localparam logic [7:0] OPC_FAR_FOURTH_SEG  = 8'hB4;
   localparam logic [7:0] OPC_FAR_FIFTH_SEG   = 8'hB5;
   localparam logic [7:0] OPC_FAR_STACK_SEG   = 8'hB2;
   localparam logic [7:0] OPC_CLEAR_CARRY     = 8'hF8;
   localparam logic [7:0] OPC_CLEAR_DIRECTION = 8'hFC;
   localparam logic [7:0] OPC_CLEAR_IRQ_EN    = 8'hFA;
   localparam logic [7:0] OPC_CLEAR_TASK_SW   = 8'h06;
   localparam logic [7:0] OPC_TOGGLE_CARRY    = 8'hF5;
   localparam logic [7:0] OPC_FLAGS_TO_ACC_HI = 8'h9F;
   localparam logic [7:0] OPC_ACC_HI_TO_FLAGS = 8'h9E;
   localparam logic [7:0] OPC_POP_FLAGS       = 8'h9D;
   localparam logic [7:0] OPC_PUSH_FLAGS      = 8'h9C;

   // ---------------------------------------------------------------
   // execution clock counts
   // ---------------------------------------------------------------
   localparam cid_clk_t CNT_POP_SEG_REAL    = 5'h07;
   localparam cid_clk_t CNT_POP_SEG_PROT    = 5'h15;
   localparam cid_clk_t CNT_SWAP            = 5'h03;
   localparam cid_clk_t CNT_LOAD_EFF_ADDR   = 5'h02;
   localparam cid_clk_t CNT_FAR_REAL        = 5'h07;
   localparam cid_clk_t CNT_FAR_DE_PROT     = 5'h16;
   localparam cid_clk_t CNT_FAR_FOURTH_PROT = 5'h19;
   localparam cid_clk_t CNT_FAR_STACK_PROT  = 5'h16;
   localparam cid_clk_t CNT_CLEAR_CARRY     = 5'h02;
   localparam cid_clk_t CNT_CLEAR_DIRECTION = 5'h02;
   localparam cid_clk_t CNT_CLEAR_IRQ_EN    = 5'h08;
   localparam cid_clk_t CNT_CLEAR_TASK_SW   = 5'h06;
   localparam cid_clk_t CNT_TOGGLE_CARRY    = 5'h02;
   localparam cid_clk_t CNT_FLAGS_TO_ACC_HI = 5'h02;
   localparam cid_clk_t CNT_ACC_HI_TO_FLAGS = 5'h03;
   localparam cid_clk_t CNT_POP_FLAGS       = 5'h05;
   localparam cid_clk_t CNT_PUSH_FLAGS      = 5'h04;
   localparam cid_clk_t CNT_NONE            = 5'h00;

endpackage

// *** rtl/cid_classify.sv ***
`timescale 1ns/1ps
`default_nettype none
module cid_classify
   import cid_pkg::*;
(
   // opcode byte and prefix state
   input  wire logic [7:0] opc,
   input  wire logic       esc,
   // classification
   output var  cid_instr_e instr,
   output var  logic       need_modrm
);

   always_comb begin
      instr = INS_NONE;
      if (esc) begin
         case (opc)
            OPC_POP_FOURTH_SEG: instr = INS_POP_FOURTH_SEG;
            OPC_POP_FIFTH_SEG:  instr = INS_POP_FIFTH_SEG;
            OPC_FAR_FOURTH_SEG: instr = INS_LOAD_FAR_PTR_FOURTH_SEG;
            OPC_FAR_FIFTH_SEG:  instr = INS_LOAD_FAR_PTR_FIFTH_SEG;
            OPC_FAR_STACK_SEG:  instr = INS_LOAD_FAR_PTR_STACK_SEG;
            OPC_CLEAR_TASK_SW:  instr = INS_CLEAR_TASK_SWITCHED;
            default:            instr = INS_NONE;
         endcase
      end else begin
         case (opc)
            OPC_LOAD_EFF_ADDR:   instr = INS_LOAD_EFFECTIVE_ADDR;
            OPC_FAR_DATA_SEG:    instr = INS_LOAD_FAR_PTR_DATA_SEG;
            OPC_FAR_EXTRA_SEG:   instr = INS_LOAD_FAR_PTR_EXTRA_SEG;
            OPC_CLEAR_CARRY:     instr = INS_CLEAR_CARRY;
            OPC_CLEAR_DIRECTION: instr = INS_CLEAR_DIRECTION;
            OPC_CLEAR_IRQ_EN:    instr = INS_CLEAR_IRQ_ENABLE;
            OPC_TOGGLE_CARRY:    instr = INS_TOGGLE_CARRY;
            OPC_FLAGS_TO_ACC_HI: instr = INS_COPY_FLAGS_TO_ACC_HIGH;
            OPC_ACC_HI_TO_FLAGS: instr = INS_COPY_ACC_HIGH_TO_FLAGS;
            OPC_POP_FLAGS:       instr = INS_POP_FLAGS;
            OPC_PUSH_FLAGS:      instr = INS_PUSH_FLAGS;
            default: begin
               if (opc[7:3] == OPC_SWAP_ACC_HI) begin
                  instr = INS_SWAP_OPERANDS;
               end
            end
         endcase
      end
   end

   // these forms carry a mod reg r/m byte after the opcode
   always_comb begin
      case (instr)
         INS_LOAD_EFFECTIVE_ADDR, INS_LOAD_FAR_PTR_DATA_SEG,
         INS_LOAD_FAR_PTR_EXTRA_SEG, INS_LOAD_FAR_PTR_FOURTH_SEG,
         INS_LOAD_FAR_PTR_FIFTH_SEG, INS_LOAD_FAR_PTR_STACK_SEG: need_modrm = 1'b1;
         default: need_modrm = 1'b0;
      endcase
   end

endmodule // cid_classify
`default_nettype wire

// *** rtl/cid_count_sel.sv ***
`timescale 1ns/1ps
`default_nettype none
module cid_count_sel
   import cid_pkg::*;
(
   // instruction and mode
   input  wire cid_instr_e instr,
   input  wire logic       prot,
   // count
   output var  cid_clk_t   clocks,
   output var  logic       known
);

   always_comb begin
      known  = 1'b1;
      clocks = CNT_NONE;
      case (instr)
         INS_POP_FOURTH_SEG, INS_POP_FIFTH_SEG:
            clocks = prot ? CNT_POP_SEG_PROT : CNT_POP_SEG_REAL;
         INS_SWAP_OPERANDS:          clocks = CNT_SWAP;
         INS_LOAD_EFFECTIVE_ADDR:    clocks = CNT_LOAD_EFF_ADDR;
         INS_LOAD_FAR_PTR_DATA_SEG, INS_LOAD_FAR_PTR_EXTRA_SEG:
            clocks = prot ? CNT_FAR_DE_PROT : CNT_FAR_REAL;
         INS_LOAD_FAR_PTR_FOURTH_SEG, INS_LOAD_FAR_PTR_FIFTH_SEG:
            clocks = prot ? CNT_FAR_FOURTH_PROT : CNT_FAR_REAL;
         INS_LOAD_FAR_PTR_STACK_SEG:
            clocks = prot ? CNT_FAR_STACK_PROT : CNT_FAR_REAL;
         INS_CLEAR_CARRY:            clocks = CNT_CLEAR_CARRY;
         INS_CLEAR_DIRECTION:        clocks = CNT_CLEAR_DIRECTION;
         INS_CLEAR_IRQ_ENABLE:       clocks = CNT_CLEAR_IRQ_EN;
         INS_CLEAR_TASK_SWITCHED:    clocks = CNT_CLEAR_TASK_SW;
         INS_TOGGLE_CARRY:           clocks = CNT_TOGGLE_CARRY;
         INS_COPY_FLAGS_TO_ACC_HIGH: clocks = CNT_FLAGS_TO_ACC_HI;
         INS_COPY_ACC_HIGH_TO_FLAGS: clocks = CNT_ACC_HI_TO_FLAGS;
         INS_POP_FLAGS:              clocks = CNT_POP_FLAGS;
         INS_PUSH_FLAGS:             clocks = CNT_PUSH_FLAGS;
         default:                    known  = 1'b0;
      endcase
   end

endmodule // cid_count_sel
`default_nettype wire

// *** sim/cid_prefetch_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module cid_prefetch_model
   import cid_pkg::*;
(
   // clock
   input  wire logic      clk,
   // bytes towards the decoder
   output var  cid_byte_s opc_in
);

   logic [7:0] last_q;

   initial begin
      opc_in = '0;
      last_q = 8'h00;
   end

   // ---------------------------------------------------------------
   // byte delivery, launched on the falling edge
   // ---------------------------------------------------------------
   task automatic send(input logic [7:0] b);
      @(negedge clk);
      opc_in <= {1'b1, b};
      last_q <= b;
   endtask

   // idle data keeps toggling so a stale byte can never pass for a real one
   task automatic idle(input int n);
      repeat (n) begin
         @(negedge clk);
         opc_in <= {1'b0, ~last_q};
         last_q <= ~last_q;
      end
   endtask

endmodule // cid_prefetch_model
`default_nettype wire

// *** sim/cid_decoder_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module cid_decoder_tb
   import cid_pkg::*;
;

   logic        CLK = 1'b0;
   logic        SRST;
   logic        MODE_PROT;
   cid_byte_s   OPC_IN;
   cid_result_s DEC_OUT;
   int          fail_count;
   int          num_checks;
   int          cyc;
   logic [31:0] rng;
   logic        esc;
   logic        skip;
   cid_result_s exp_q [0:3];

   localparam logic [7:0] POOL [0:18] = '{8'h0F, 8'h90, 8'h8D, 8'hC5, 8'hC4, 8'hF8, 8'hFC, 8'hFA, 8'hF5, 8'h9F,
                                          8'h9E, 8'h9D, 8'h9C, 8'hA1, 8'hA9, 8'hB4, 8'hB5, 8'hB2, 8'h06};

   cid_decoder cid_decoder_i (
      .CLK       (CLK),
      .SRST      (SRST),
      .OPC_IN    (OPC_IN),
      .MODE_PROT (MODE_PROT),
      .DEC_OUT   (DEC_OUT)
   );

   cid_prefetch_model cid_prefetch_model_i (
      .clk    (CLK),
      .opc_in (OPC_IN)
   );

   always #2 CLK = ~CLK;

   // ---------------------------------------------------------------
   // expected results
   // ---------------------------------------------------------------
   function automatic logic [31:0] rnd();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction

   function automatic cid_result_s mk(input cid_instr_e i, input cid_clk_t c, input logic m);
      mk = '0;
      mk.valid = 1'b1;
      mk.known = 1'b1;
      mk.instr = i;
      mk.clocks = c;
      mk.modrm_next = m;
   endfunction

   // unknown bytes keep valid set, and escaped after a prefix: no count, no instruction code
   function automatic cid_result_s exp_of(input logic e, input logic [7:0] b, input logic p);
      cid_result_s r;
      r = '0;
      r.valid = 1'b1;
      if (e) begin
         case (b)
            8'hA1: r = mk(INS_POP_FOURTH_SEG, p ? 5'h15 : 5'h07, 1'b0);
            8'hA9: r = mk(INS_POP_FIFTH_SEG, p ? 5'h15 : 5'h07, 1'b0);
            8'hB4: r = mk(INS_LOAD_FAR_PTR_FOURTH_SEG, p ? 5'h19 : 5'h07, 1'b1);
            8'hB5: r = mk(INS_LOAD_FAR_PTR_FIFTH_SEG, p ? 5'h19 : 5'h07, 1'b1);
            8'hB2: r = mk(INS_LOAD_FAR_PTR_STACK_SEG, p ? 5'h16 : 5'h07, 1'b1);
            8'h06: r = mk(INS_CLEAR_TASK_SWITCHED, 5'h06, 1'b0);
            default: ;
         endcase
      end else if (b[7:3] == 5'b10010) begin
         r = mk(INS_SWAP_OPERANDS, 5'h03, 1'b0);
      end else begin
         case (b)
            8'h8D: r = mk(INS_LOAD_EFFECTIVE_ADDR, 5'h02, 1'b1);
            8'hC5: r = mk(INS_LOAD_FAR_PTR_DATA_SEG, p ? 5'h16 : 5'h07, 1'b1);
            8'hC4: r = mk(INS_LOAD_FAR_PTR_EXTRA_SEG, p ? 5'h16 : 5'h07, 1'b1);
            8'hF8: r = mk(INS_CLEAR_CARRY, 5'h02, 1'b0);
            8'hFC: r = mk(INS_CLEAR_DIRECTION, 5'h02, 1'b0);
            8'hFA: r = mk(INS_CLEAR_IRQ_ENABLE, 5'h08, 1'b0);
            8'hF5: r = mk(INS_TOGGLE_CARRY, 5'h02, 1'b0);
            8'h9F: r = mk(INS_COPY_FLAGS_TO_ACC_HIGH, 5'h02, 1'b0);
            8'h9E: r = mk(INS_COPY_ACC_HIGH_TO_FLAGS, 5'h03, 1'b0);
            8'h9D: r = mk(INS_POP_FLAGS, 5'h05, 1'b0);
            8'h9C: r = mk(INS_PUSH_FLAGS, 5'h04, 1'b0);
            default: ;
         endcase
      end
      r.escaped = e;
      return r;
   endfunction

   // ---------------------------------------------------------------
   // checking and closing
   // ---------------------------------------------------------------
   task automatic check_res(input cid_result_s got, input cid_result_s exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected result at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic complete_run();
      if (fail_count == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // every cycle is compared: an empty slot means the result must be all zero
   always @(negedge CLK) begin
      check_res(DEC_OUT, exp_q[cyc % 4]);
      exp_q[cyc % 4] = '0;
   end

   always @(posedge CLK) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         fail_count++;
         complete_run();
      end
   end

   // ---------------------------------------------------------------
   // stimulus
   // ---------------------------------------------------------------
   // result is due right after the edge that takes the last opcode byte
   task automatic put(input logic [7:0] b, input logic p);
      cid_result_s r;
      cid_prefetch_model_i.send(b);
      MODE_PROT <= p;
      if (skip) begin
         skip = 1'b0;
      end else if (!esc && b == 8'h0F) begin
         esc = 1'b1;
      end else begin
         r = exp_of(esc, b, p);
         esc = 1'b0;
         skip = r.modrm_next;
         exp_q[(cyc + 1) % 4] = r;
      end
   endtask

   task automatic do_reset(input int n);
      SRST <= 1'b1;
      cid_prefetch_model_i.idle(n);
      SRST <= 1'b0;
      esc = 1'b0;
      skip = 1'b0;
   endtask

   initial begin
      logic [31:0] r;
      logic [7:0]  b;
      SRST = 1'b1;
      MODE_PROT = 1'b0;
      fail_count = 0;
      num_checks = 0;
      cyc = 0;
      rng = 32'h1F4241C4;
      esc = 1'b0;
      skip = 1'b0;
      for (int i = 0; i < 4; i++) begin
         exp_q[i] = '0;
      end
      do_reset(12);
      // every known opcode back to back, in both modes
      for (int m = 0; m < 2; m++) begin
         for (int i = 1; i < 19; i++) begin
            if (i >= 13) begin
               put(8'h0F, m[0]);
            end
            if (i == 1) begin
               for (int k = 0; k < 8; k++) begin
                  put(8'h90 + 8'(k), m[0]);
               end
            end else begin
               put(POOL[i], m[0]);
            end
            if (skip) begin
               r = rnd();
               put(r[7:0], r[8]);
            end
         end
      end
      // unknown plain, double escape, escaped unknown, escape value as mod reg r/m byte
      put(8'h00, 1'b0);
      put(8'h0F, 1'b1);
      put(8'h0F, 1'b1);
      put(8'h0F, 1'b0);
      put(8'hFF, 1'b0);
      put(8'hC4, 1'b1);
      put(8'h0F, 1'b0);
      put(8'hF8, 1'b1);
      // reset in mid escape must drop the pending prefix
      put(8'h0F, 1'b1);
      do_reset(2);
      put(8'hF8, 1'b0);
      // random stream with occasional gaps
      repeat (3000) begin
         r = rnd();
         b = r[4] ? r[15:8] : POOL[r[20:16] % 19];
         if (b == 8'h90) begin
            b[2:0] = r[2:0];
         end
         put(b, r[24]);
         if (r[27:26] == 2'b00) begin
            cid_prefetch_model_i.idle(1 + int'(r[29:28]));
         end
      end
      cid_prefetch_model_i.idle(4);
      complete_run();
   end

endmodule // cid_decoder_tb
`default_nettype wire
